//--- verilog/sri_pkg.sv
// constants for the safety output restart interlock
package sri_pkg;
	localparam int SRI_CLK_HZ = 10_000_000;
	localparam int SRI_MIN_OFF_MS = 80;
	localparam int SRI_MIN_OFF_CYC = SRI_CLK_HZ / 1000 * SRI_MIN_OFF_MS;
	localparam int SRI_NUM_OUT = 2;
	localparam int SRI_NUM_UIN = 4;
	localparam int SRI_NUM_UOUT = 2;
	localparam logic [1:0] SRI_UOUT_OFF = 2'h0;
	localparam logic [1:0] SRI_UOUT_RST_REQ = 2'h1;
	localparam logic [1:0] SRI_UOUT_OSSD = 2'h2;
	localparam logic [1:0] SRI_UOUT_ON = 2'h3;
	typedef enum logic [1:0] {
		SRI_ST_ON = 2'b00,
		SRI_ST_HOLD = 2'b01,
		SRI_ST_LATCH = 2'b10
	} sri_state_e;
endpackage

//--- verilog/sri_channel.sv
// one safety output channel with its restart interlock
`timescale 1ns/1ps
module sri_channel
	import sri_pkg::*;
#(
	parameter int MIN_OFF_CYC = SRI_MIN_OFF_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// field and control
	input wire logic i_field_int,
	input wire logic i_ril_en,
	input wire logic i_reset_pulse,
	// result
	output logic o_out_on,
	output logic o_rst_required
);
	localparam int CW = $clog2(MIN_OFF_CYC + 1);
	initial begin
		if (MIN_OFF_CYC < 1) begin
			$error("MIN_OFF_CYC must be at least 1");
		end
	end

	sri_state_e state_reg;
	logic [CW-1:0] cnt_reg;
	logic hold_done;
	assign hold_done = (cnt_reg == CW'(MIN_OFF_CYC - 1));

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			state_reg <= SRI_ST_ON;
		end else begin
			unique case (state_reg)
				SRI_ST_ON: begin
					if (i_field_int) begin
						state_reg <= SRI_ST_HOLD;
					end
				end
				SRI_ST_HOLD: begin
					if (hold_done && !i_field_int) begin
						state_reg <= i_ril_en ? SRI_ST_LATCH : SRI_ST_ON;
					end
				end
				SRI_ST_LATCH: begin
					if (i_field_int) begin
						state_reg <= SRI_ST_HOLD;
					end else if (i_reset_pulse) begin
						state_reg <= SRI_ST_ON;
					end
				end
				default: state_reg <= SRI_ST_HOLD;
			endcase
		end
	end

	// minimum off time counter, restarts on every interruption
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			cnt_reg <= '0;
		end else if (state_reg != SRI_ST_HOLD || i_field_int) begin
			cnt_reg <= '0;
		end else if (!hold_done) begin
			cnt_reg <= cnt_reg + CW'(1);
		end
	end

	assign o_out_on = (state_reg == SRI_ST_ON) && !i_field_int;
	assign o_rst_required = (state_reg == SRI_ST_LATCH);

	////////////////////////////////////////////////////////////////////
	// off time counter in helper logic
	int unsigned off_cnt;
	always_ff @(posedge i_clk) begin
		if (!i_resetn || o_out_on) begin
			off_cnt <= 0;
		end else begin
			off_cnt <= off_cnt + 1;
		end
	end

	property p_field_off;
		@(posedge i_clk) disable iff (!i_resetn) i_field_int |-> !o_out_on;
	endproperty
	a_field_off: assert property (p_field_off) else $error("output on during field");

	property p_min_off;
		@(posedge i_clk) disable iff (!i_resetn)
			$rose(o_out_on) |-> ($past(off_cnt) >= MIN_OFF_CYC);
	endproperty
	a_min_off: assert property (p_min_off) else $error("off time too short");

	property p_latch_stays;
		@(posedge i_clk) disable iff (!i_resetn)
			(o_rst_required && !i_reset_pulse) |=> !o_out_on;
	endproperty
	a_latch_stays: assert property (p_latch_stays) else $error("latched output re-armed");

	sequence s_reset_ok;
		o_rst_required && i_reset_pulse && !i_field_int;
	endsequence
	property p_reset_arms;
		@(posedge i_clk) disable iff (!i_resetn)
			s_reset_ok ##1 !i_field_int |-> o_out_on;
	endproperty
	a_reset_arms: assert property (p_reset_arms) else $error("reset did not arm");

	property p_reset_ignored;
		@(posedge i_clk) disable iff (!i_resetn)
			(o_rst_required && i_field_int) |=> !o_out_on;
	endproperty
	a_reset_ignored: assert property (p_reset_ignored) else $error("reset taken in field");

	property p_auto;
		@(posedge i_clk) disable iff (!i_resetn)
			!i_ril_en |-> !o_rst_required || $past(i_ril_en);
	endproperty
	a_auto: assert property (p_auto) else $error("latched with interlock off");
endmodule

//--- verilog/sri_top.sv
// restart interlock in front of the safety outputs
`timescale 1ns/1ps
module sri_top
	import sri_pkg::*;
#(
	parameter int NUM_OUT = SRI_NUM_OUT,
	parameter int NUM_UIN = SRI_NUM_UIN,
	parameter int NUM_UOUT = SRI_NUM_UOUT,
	parameter int MIN_OFF_CYC = SRI_MIN_OFF_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// detection
	input wire logic [NUM_OUT-1:0] i_field_int,
	// configuration
	input wire logic [NUM_OUT-1:0] i_ril_en,
	input wire logic [NUM_UIN-1:0] i_uin_is_reset,
	input wire logic [2*NUM_UOUT-1:0] i_uout_func,
	// universal inputs
	input wire logic [NUM_UIN-1:0] i_uin,
	// outputs
	output logic [NUM_OUT-1:0] o_out_on,
	output logic [NUM_OUT-1:0] o_rst_required,
	output logic [NUM_UOUT-1:0] o_uout
);
	initial begin
		if (NUM_OUT < 1 || NUM_UIN < 1 || NUM_UOUT < 1) begin
			$error("channel counts must be at least 1");
		end
	end

	logic rst_lvl;
	logic rst_prev_reg;
	logic reset_pulse;
	logic [NUM_UOUT-1:0] uout_reg;

	assign rst_lvl = |(i_uin & i_uin_is_reset);

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			rst_prev_reg <= 1'b1;
		end else begin
			rst_prev_reg <= rst_lvl;
		end
	end
	assign reset_pulse = rst_lvl && !rst_prev_reg;

	////////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g < NUM_OUT; g++) begin : g_ch
			sri_channel #(
				.MIN_OFF_CYC(MIN_OFF_CYC)
			) u_ch (
				.i_clk(i_clk),
				.i_resetn(i_resetn),
				.i_field_int(i_field_int[g]),
				.i_ril_en(i_ril_en[g]),
				.i_reset_pulse(reset_pulse),
				.o_out_on(o_out_on[g]),
				.o_rst_required(o_rst_required[g])
			);
		end
		for (g = 0; g < NUM_UOUT; g++) begin : g_uo
			always_ff @(posedge i_clk) begin
				if (!i_resetn) begin
					uout_reg[g] <= 1'b0;
				end else begin
					unique case (i_uout_func[2*g +: 2])
						SRI_UOUT_OFF: uout_reg[g] <= 1'b0;
						SRI_UOUT_RST_REQ: uout_reg[g] <= |o_rst_required;
						SRI_UOUT_OSSD: uout_reg[g] <= &o_out_on;
						SRI_UOUT_ON: uout_reg[g] <= 1'b1;
					endcase
				end
			end
		end
	endgenerate
	assign o_uout = uout_reg;

	property p_edge;
		@(posedge i_clk) disable iff (!i_resetn) reset_pulse |=> !reset_pulse;
	endproperty
	a_edge: assert property (p_edge) else $error("reset pulse repeated");

	property p_src;
		@(posedge i_clk) disable iff (!i_resetn) reset_pulse |-> |(i_uin & i_uin_is_reset);
	endproperty
	a_src: assert property (p_src) else $error("reset from unselected input");

	property p_uout;
		@(posedge i_clk) disable iff (!i_resetn)
			(i_uout_func[1:0] == SRI_UOUT_RST_REQ) |=> o_uout[0] == $past(|o_rst_required);
	endproperty
	a_uout: assert property (p_uout) else $error("reset required not shown");
endmodule

//--- verif/sri_button.sv
// operator reset pushbutton model, high while pressed
`timescale 1ns/1ps
module sri_button (
	// clock the operator acts against
	input wire logic i_clk,
	// contact level
	output logic o_level
);
	initial o_level = 1'b0;
	// level changes just after an edge and stays until the next call
	task set_level(input logic v);
		@(posedge i_clk);
		#10 o_level = v;
	endtask
endmodule

//--- verif/sri_top_bench.sv
// self-checking bench for the restart interlock
`timescale 1ns/1ps
module sri_top_bench;
	import sri_pkg::*;
	localparam int MOC = 10;
	logic clk, rstn, btn;
	logic [1:0] fi, ril, on, rq, uo;
	logic [3:0] isr, uf;
	logic [2:0] up;
	int err_total = 0;
	int n_compared = 0;
	sri_button sri_button_i (.i_clk(clk), .o_level(btn));
	sri_top #(.MIN_OFF_CYC(MOC)) sri_top_i (.i_clk(clk), .i_resetn(rstn),
		.i_field_int(fi), .i_ril_en(ril), .i_uin_is_reset(isr),
		.i_uout_func(uf), .i_uin({up, btn}),
		.o_out_on(on), .o_rst_required(rq), .o_uout(uo));
	////////////////////////////////////////////////////////////////////////
	task step(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask
	task chk(input string nm, input logic [1:0] e, input logic [1:0] g);
		n_compared++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask
	task test_done;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// short interruption on both outputs, only output 0 latches
	task t_trip;
		ril = 2'h1;
		fi = 2'h3;
		#1;
		chk("out_on", 2'h0, on);
		step(1);
		fi = 2'h0;
		step(MOC - 1);
		chk("out_on", 2'h0, on);
		step(4);
		chk("out_on", 2'h2, on);
		chk("rst_required", 2'h1, rq);
		chk("uout", 2'h1, uo);
	endtask
	// press during interruption, held, wrong input, then a real press
	task t_rst;
		fi = 2'h1;
		sri_button_i.set_level(1'b1);
		step(1);
		fi = 2'h0;
		step(MOC + 4);
		chk("rst_required", 2'h1, rq);
		chk("out_on", 2'h2, on);
		sri_button_i.set_level(1'b0);
		up = 3'h1;
		step(2);
		chk("out_on", 2'h2, on);
		up = 3'h0;
		sri_button_i.set_level(1'b1);
		step(1);
		chk("out_on", 2'h3, on);
		chk("rst_required", 2'h0, rq);
		sri_button_i.set_level(1'b0);
	endtask
	// constant low and high universal output functions
	task t_uout;
		uf = {SRI_UOUT_OFF, SRI_UOUT_ON};
		step(2);
		chk("uout", 2'h1, uo);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		rstn = 1'b0;
		fi = 2'h0;
		ril = 2'h0;
		isr = 4'h1;
		uf = {SRI_UOUT_OSSD, SRI_UOUT_RST_REQ};
		up = 3'h0;
		step(3);
		rstn = 1'b1;
		step(2);
		chk("out_on", 2'h3, on);
		chk("rst_required", 2'h0, rq);
		chk("uout", 2'h2, uo);
		t_trip;
		t_rst;
		t_uout;
		test_done;
	end
	initial begin
		#(3000 * 100);
		err_total++;
		test_done;
	end
endmodule
